// ### rtl/scm_regs.vh
// Purpose: Constants of the switch contact monitor: word layouts, reset values, timing.
// Assumes: Core clock of 200 MHz; included by the tick divider and the top level of the block.
// Notes: Definitions only.
`ifndef SCM_REGS_VH
`define SCM_REGS_VH

// ****************************************************************
// Serial words
// ****************************************************************
`define SCM_WORD_W 16
`define SCM_BITCNT_W 5
`define SCM_BITCNT_FULL 5'h10

// ****************************************************************
// Command word fields
// ****************************************************************
`define SCM_CMD_MASK_LSB 0
`define SCM_CMD_MASK_MSB 7
`define SCM_CMD_POLA_BIT 8
`define SCM_CMD_POLB_BIT 9
`define SCM_CMD_HYSTERESIS_SET_PIN_BIT 10
`define SCM_CMD_WETEN_BIT 11
`define SCM_CMD_WETTING_ON_IN01_BIT 12
`define SCM_CMD_SCAN_LSB 13
`define SCM_CMD_SCAN_MSB 15
`define SCM_CMD_RESET 16'h0000

// ****************************************************************
// Status word fields
// ****************************************************************
`define SCM_STAT_SW_LSB 0
`define SCM_STAT_SW_MSB 7
`define SCM_STAT_OT_BIT 8
`define SCM_STAT_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
// Two hundred cycles of 5 ns make the 1 us tick.
`define SCM_TICK_CYC 8'hC8
`define SCM_SCAN_PULSE_US 18'h000FA
`define SCM_SCAN_UNIT_US 18'h003E8
`define SCM_TIMER_W 18
`define SCM_DEB_W 25

// ****************************************************************
// Operating states
// ****************************************************************
`define SCM_ST_W 3

`endif

// ### rtl/scm_sync.v
// Purpose: Two-flop synchroniser for a vector of asynchronous levels.
// Assumes: Each bit is an independent level; reset value is zero.
// Notes: The first stage feeds only the second stage.
module scm_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Levels
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

// ### rtl/scm_tick.v
// Purpose: Divider that gives a one-cycle enable pulse every fixed number of cycles.
// Assumes: Period of at least two cycles.
// Notes: Used as the microsecond time base of the scan sequencer.
`include "scm_regs.vh"
module scm_tick #(
   parameter [7:0] PERIOD = `SCM_TICK_CYC
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Enable pulse
   output reg tick
);

   reg [7:0] cnt_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         tick <= 1'b0;
      end else if (cnt_reg == PERIOD - 8'h01) begin
         cnt_reg <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         tick <= 1'b0;
      end
   end

endmodule

// ### rtl/scm_top.v
// Purpose: Digital core of an eight-channel mechanical switch contact monitor.
// Assumes: Switch inputs arrive as comparator levels; serial lines from an external master.
// Notes: Open-drain pins are output plus enable; the enable is high while the pin is pulled low.
`include "scm_regs.vh"
module scm_top #(
   parameter [`SCM_TIMER_W-1:0] SCAN_PULSE_US = `SCM_SCAN_PULSE_US,
   parameter [`SCM_TIMER_W-1:0] SCAN_UNIT_US = `SCM_SCAN_UNIT_US
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Serial port
   input wire spi_sck,
   input wire spi_cs_n,
   input wire spi_sdi,
   output reg spi_sdo_o,
   output reg spi_sdo_oe,
   // Switch inputs and analog status
   input wire [7:0] switch_inputs,
   input wire thermal_warn,
   input wire shutdown_n,
   input wire [`SCM_DEB_W-1:0] debounce_cycles,
   // Open-drain alerts
   output wire switch_change_irq_n_o,
   output reg switch_change_irq_n_oe,
   output wire overtemp_warn_n_o,
   output reg overtemp_warn_n_oe,
   // Direct level-shifted outputs
   output reg direct_out0,
   output reg direct_out1,
   output reg direct_out_oe,
   // Analog front-end controls
   output reg [7:0] sense_enable,
   output reg [7:0] wetting_enable,
   output reg [7:0] battery_reference,
   output reg hysteresis_enable
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   function [`SCM_TIMER_W-1:0] scm_period;
      input [2:0] sel;
      begin
         scm_period = SCAN_UNIT_US << sel;
      end
   endfunction

   // ****************************************************************
   // Synchronisers and edge detection
   // ****************************************************************
   wire [12:0] sync_w;
   wire sck_s;
   wire cs_act_s;
   wire sdi_s;
   wire sd_s;
   wire therm_s;
   wire [7:0] in_s;
   reg sck_d_reg;
   reg cs_d_reg;
   reg therm_d_reg;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire cs_rise;
   wire tick;

   scm_sync #(.W(13)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({switch_inputs, thermal_warn, shutdown_n, spi_sdi, ~spi_cs_n, spi_sck}),
      .sync_out(sync_w)
   );

   scm_tick u_tick (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   assign sck_s = sync_w[0];
   assign cs_act_s = sync_w[1];
   assign sdi_s = sync_w[2];
   assign sd_s = sync_w[3];
   assign therm_s = sync_w[4];
   assign in_s = sync_w[12:5];
   assign sck_rise = cs_act_s & sck_s & ~sck_d_reg;
   assign sck_fall = cs_act_s & ~sck_s & sck_d_reg;
   assign cs_fall = cs_act_s & ~cs_d_reg;
   assign cs_rise = ~cs_act_s & cs_d_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b0;
         therm_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= sck_s;
         cs_d_reg <= cs_act_s;
         therm_d_reg <= therm_s;
      end
   end

   // ****************************************************************
   // Command word and decoded settings
   // ****************************************************************
   reg [`SCM_WORD_W-1:0] cmd_reg;
   reg [`SCM_STAT_SW_MSB:0] status_reg;
   wire [7:0] irq_mask;
   wire pair_polarity_sel_a;
   wire pair_polarity_sel_b;
   wire wetting_on_in01;
   wire [2:0] scan_sel;
   wire [7:0] valid_w;
   wire [7:0] inv_w;
   wire [`SCM_WORD_W-1:0] status_word;

   assign irq_mask = cmd_reg[`SCM_CMD_MASK_MSB:`SCM_CMD_MASK_LSB];
   assign pair_polarity_sel_a = cmd_reg[`SCM_CMD_POLA_BIT];
   assign pair_polarity_sel_b = cmd_reg[`SCM_CMD_POLB_BIT];
   assign wetting_on_in01 = cmd_reg[`SCM_CMD_WETTING_ON_IN01_BIT];
   assign scan_sel = cmd_reg[`SCM_CMD_SCAN_MSB:`SCM_CMD_SCAN_LSB];
   // Inputs 0 and 1 take part in monitoring only when their wetting is on.
   assign valid_w = {6'h3F, wetting_on_in01, wetting_on_in01};
   // A ground-referenced switch reads closed when the line is low.
   assign inv_w = {{2{~pair_polarity_sel_b}}, {2{~pair_polarity_sel_a}}, 4'hF};
   assign status_word = {7'h00, therm_s, status_reg};

   // ****************************************************************
   // Serial shift logic
   // ****************************************************************
   reg [`SCM_WORD_W-1:0] tx_reg;
   reg [`SCM_WORD_W-1:0] rx_reg;
   reg [`SCM_BITCNT_W-1:0] bitcnt_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_reg <= 16'h0000;
         rx_reg <= 16'h0000;
         bitcnt_reg <= 5'h00;
         cmd_reg <= `SCM_CMD_RESET;
         spi_sdo_o <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         spi_sdo_oe <= cs_act_s;
         if (cs_fall) begin
            tx_reg <= status_word;
            bitcnt_reg <= 5'h00;
         end else if (sck_rise) begin
            spi_sdo_o <= tx_reg[`SCM_WORD_W-1];
            tx_reg <= {tx_reg[`SCM_WORD_W-2:0], 1'b0};
         end else if (sck_fall) begin
            rx_reg <= {rx_reg[`SCM_WORD_W-2:0], sdi_s};
            if (bitcnt_reg != `SCM_BITCNT_FULL) begin
               bitcnt_reg <= bitcnt_reg + 5'h01;
            end
         end
         // Only a frame of sixteen bits or more replaces the command word, with its last sixteen bits.
         if (cs_rise && bitcnt_reg == `SCM_BITCNT_FULL) begin
            cmd_reg <= rx_reg;
         end
      end
   end

   // ****************************************************************
   // Operating mode sequencer
   // ****************************************************************
   localparam [`SCM_ST_W-1:0] ST_OFF = 3'h0;
   localparam [`SCM_ST_W-1:0] ST_NORM = 3'h1;
   localparam [`SCM_ST_W-1:0] ST_SWAIT = 3'h2;
   localparam [`SCM_ST_W-1:0] ST_SSENSE = 3'h3;
   localparam [`SCM_ST_W-1:0] ST_SDEB = 3'h4;
   reg [`SCM_ST_W-1:0] state_reg;
   reg [`SCM_ST_W-1:0] state_next;
   reg [`SCM_TIMER_W-1:0] timer_reg;
   reg [`SCM_TIMER_W-1:0] timer_next;
   wire [7:0] target_w;
   wire diff_w;
   wire deb_active;
   wire deb_fire;
   wire deb_quiet;

   assign deb_active = (state_reg == ST_NORM) || (state_reg == ST_SDEB);
   assign target_w = (in_s ^ inv_w) & valid_w;
   assign diff_w = (target_w != status_reg);

   always @* begin
      state_next = state_reg;
      timer_next = timer_reg;
      case (state_reg)
         ST_OFF: begin
            timer_next = {`SCM_TIMER_W{1'b0}};
            if (sd_s) begin
               state_next = (scan_sel == 3'h0) ? ST_NORM : ST_SWAIT;
            end
         end
         ST_NORM: begin
            if (scan_sel != 3'h0 && !diff_w) begin
               state_next = ST_SWAIT;
               timer_next = {`SCM_TIMER_W{1'b0}};
            end
         end
         ST_SWAIT: begin
            if (scan_sel == 3'h0) begin
               state_next = ST_NORM;
            end else if (tick) begin
               if (timer_reg >= scm_period(scan_sel) - SCAN_PULSE_US) begin
                  state_next = ST_SSENSE;
                  timer_next = {`SCM_TIMER_W{1'b0}};
               end else begin
                  timer_next = timer_reg + 18'h00001;
               end
            end
         end
         ST_SSENSE: begin
            if (tick) begin
               if (timer_reg >= SCAN_PULSE_US - 18'h00001) begin
                  // The window closes; a change seen here is debounced with sensing held on.
                  state_next = diff_w ? ST_SDEB : ST_SWAIT;
                  timer_next = {`SCM_TIMER_W{1'b0}};
               end else begin
                  timer_next = timer_reg + 18'h00001;
               end
            end
         end
         ST_SDEB: begin
            if (deb_fire || deb_quiet) begin
               state_next = ST_SWAIT;
               timer_next = {`SCM_TIMER_W{1'b0}};
            end
         end
         default: begin
            state_next = ST_OFF;
            timer_next = {`SCM_TIMER_W{1'b0}};
         end
      endcase
      if (!sd_s) begin
         state_next = ST_OFF;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_OFF;
         timer_reg <= {`SCM_TIMER_W{1'b0}};
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
      end
   end

   // ****************************************************************
   // Shared debounce timer
   // ****************************************************************
   reg [`SCM_DEB_W-1:0] deb_cnt_reg;
   reg [7:0] cand_reg;
   wire [7:0] changed_w;

   assign deb_quiet = !diff_w;
   assign deb_fire = deb_active && diff_w && (target_w == cand_reg) &&
                     (deb_cnt_reg >= debounce_cycles);
   assign changed_w = (target_w ^ status_reg) & ~irq_mask;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         deb_cnt_reg <= {`SCM_DEB_W{1'b0}};
         cand_reg <= 8'h00;
         status_reg <= `SCM_STAT_RESET;
      end else begin
         if (!deb_active || !diff_w || target_w != cand_reg) begin
            // A reversion or a new pattern restarts the single common timer.
            deb_cnt_reg <= {`SCM_DEB_W{1'b0}};
            cand_reg <= target_w;
         end else if (!deb_fire) begin
            deb_cnt_reg <= deb_cnt_reg + 25'h0000001;
         end else begin
            deb_cnt_reg <= {`SCM_DEB_W{1'b0}};
         end
         if (deb_fire) begin
            status_reg <= target_w;
         end else begin
            status_reg <= status_reg & valid_w;
         end
      end
   end

   // ****************************************************************
   // Alerts
   // ****************************************************************
   assign switch_change_irq_n_o = 1'b0;
   assign overtemp_warn_n_o = 1'b0;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         switch_change_irq_n_oe <= 1'b0;
         overtemp_warn_n_oe <= 1'b0;
      end else begin
         // A new event in the clearing cycle keeps the alert asserted.
         if (deb_fire && changed_w != 8'h00) begin
            switch_change_irq_n_oe <= 1'b1;
         end else if (cs_fall) begin
            switch_change_irq_n_oe <= 1'b0;
         end
         if (therm_s && !therm_d_reg) begin
            overtemp_warn_n_oe <= 1'b1;
         end else if (cs_fall) begin
            overtemp_warn_n_oe <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Front-end controls and direct outputs
   // ****************************************************************
   wire sensing_w;
   wire normal_w;

   assign sensing_w = (state_reg == ST_NORM) || (state_reg == ST_SSENSE) ||
                      (state_reg == ST_SDEB);
   assign normal_w = (state_reg == ST_NORM);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         direct_out0 <= 1'b0;
         direct_out1 <= 1'b0;
         direct_out_oe <= 1'b0;
         sense_enable <= 8'h00;
         wetting_enable <= 8'h00;
         battery_reference <= 8'h00;
         hysteresis_enable <= 1'b0;
      end else begin
         direct_out_oe <= normal_w && !wetting_on_in01;
         direct_out0 <= in_s[0];
         direct_out1 <= in_s[1];
         sense_enable <= sensing_w ? valid_w : 8'h00;
         wetting_enable <= (sensing_w && cmd_reg[`SCM_CMD_WETEN_BIT] && !therm_s) ?
                           (status_reg & valid_w) : 8'h00;
         battery_reference <= ~inv_w;
         hysteresis_enable <= cmd_reg[`SCM_CMD_HYSTERESIS_SET_PIN_BIT];
      end
   end

endmodule

// ### tb/scm_top_asserts.sv
// Purpose: Concurrent checks on the ports of the contact monitor core.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to scm_top at the foot of this file.
module scm_top_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Stimulus side
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic thermal_warn,
   input wire logic shutdown_n,
   input wire logic [7:0] switch_inputs,
   // Design outputs
   input wire logic spi_sdo_o,
   input wire logic spi_sdo_oe,
   input wire logic switch_change_irq_n_oe,
   input wire logic overtemp_warn_n_oe,
   input wire logic direct_out0,
   input wire logic direct_out1,
   input wire logic direct_out_oe,
   input wire logic [7:0] sense_enable,
   input wire logic [7:0] wetting_enable,
   input wire logic [7:0] battery_reference
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_shut_held;
      !shutdown_n [*6];
   endsequence
   sequence s_cs_fall;
      $fell(spi_cs_n);
   endsequence
   property p_bat_fixed;
      battery_reference[3:0] == 4'h0 && battery_reference[5] == battery_reference[4]
         && battery_reference[7] == battery_reference[6];
   endproperty
   a_bat_fixed: assert property (p_bat_fixed) else $error("pair reference split");
   property p_sdo_off;
      spi_cs_n [*8] |-> !spi_sdo_oe;
   endproperty
   a_sdo_off: assert property (p_sdo_off) else $error("sdo driven while idle");
   property p_sdo_on;
      s_cs_fall |-> ##[1:5] spi_sdo_oe;
   endproperty
   a_sdo_on: assert property (p_sdo_on) else $error("sdo not driven in frame");
   property p_sdo_edge;
      $changed(spi_sdo_o) |-> $past(spi_sck, 3);
   endproperty
   a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved off rising sck");
   property p_irq_release;
      s_cs_fall |-> ##[1:5] !switch_change_irq_n_oe;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("irq kept on select");
   property p_ot_set;
      $rose(thermal_warn) |-> ##[2:6] overtemp_warn_n_oe;
   endproperty
   a_ot_set: assert property (p_ot_set) else $error("warning not raised");
   property p_shut_sense;
      s_shut_held |-> sense_enable == 8'h00 && wetting_enable == 8'h00;
   endproperty
   a_shut_sense: assert property (p_shut_sense) else $error("sensing in shutdown");
   property p_shut_direct;
      s_shut_held |-> !direct_out_oe;
   endproperty
   a_shut_direct: assert property (p_shut_direct) else $error("direct out in shutdown");
   property p_direct_copy;
      $stable(switch_inputs[1:0]) [*5] |->
         direct_out0 == switch_inputs[0] && direct_out1 == switch_inputs[1];
   endproperty
   a_direct_copy: assert property (p_direct_copy) else $error("direct copy wrong");
   property p_wet_sense;
      (wetting_enable & ~sense_enable) == 8'h00;
   endproperty
   a_wet_sense: assert property (p_wet_sense) else $error("wetting without sensing");
   property p_direct_off;
      direct_out_oe |-> sense_enable[1:0] == 2'h0 && wetting_enable[1:0] == 2'h0;
   endproperty
   a_direct_off: assert property (p_direct_off) else $error("direct input sensed");
endmodule

bind scm_top scm_top_asserts scm_top_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
   .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .thermal_warn(thermal_warn),
   .shutdown_n(shutdown_n), .switch_inputs(switch_inputs), .spi_sdo_o(spi_sdo_o),
   .spi_sdo_oe(spi_sdo_oe), .switch_change_irq_n_oe(switch_change_irq_n_oe),
   .overtemp_warn_n_oe(overtemp_warn_n_oe), .direct_out0(direct_out0),
   .direct_out1(direct_out1), .direct_out_oe(direct_out_oe), .sense_enable(sense_enable),
   .wetting_enable(wetting_enable), .battery_reference(battery_reference));

// ### tb/scm_spi_master.sv
// Purpose: Serial master model that sends a command word and collects the status word.
// Assumes: Clock idles low; both sides sample on falling clock edges.
// Notes: The frame length is an argument so that short frames can be sent.
module scm_spi_master (
   // Serial lines
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      spi_cs_n = 1'b0;
      #128;
      for (int i = nbits - 1; i >= 0; i--) begin
         spi_sdi = tx[i];
         spi_sck = 1'b1;
         #32;
         rx = {rx[14:0], spi_sdo};
         spi_sck = 1'b0;
         #32;
      end
      #32;
      // Data is driven low again before the select is released.
      spi_sdi = 1'b0;
      spi_cs_n = 1'b1;
      #64;
   endtask
endmodule

// ### tb/tb_scm_top.sv
// Purpose: Self-checking bench for the switch contact monitor core.
// Assumes: Scan timing shortened through parameters; debounce count of 20 cycles.
// Notes: Open-drain alerts are resolved with pull-ups in this module.
module tb_scm_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEB = 20;
   logic core_clk, rst_n, thermal_warn, shutdown_n;
   logic [7:0] switch_inputs, sense_enable, wetting_enable, battery_reference;
   logic spi_sdo_o, spi_sdo_oe, irq_o, irq_oe, ot_o, ot_oe;
   logic direct_out0, direct_out1, direct_out_oe, hysteresis_enable;
   wire spi_sck, spi_cs_n, spi_sdi, sdo_line;
   int mismatches, checks, cycles;
   logic [15:0] base, rd, cmd;
   logic [24:0] deb_cycles;
   wire irq_pin = irq_oe ? irq_o : 1'b1;
   wire ot_pin = ot_oe ? ot_o : 1'b1;
   assign sdo_line = spi_sdo_oe ? spi_sdo_o : 1'bz;
   scm_top #(.SCAN_PULSE_US(18'h4), .SCAN_UNIT_US(18'h10)) scm_top_i (
      .core_clk(core_clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
      .switch_inputs(switch_inputs), .thermal_warn(thermal_warn), .shutdown_n(shutdown_n),
      .debounce_cycles(deb_cycles), .switch_change_irq_n_o(irq_o),
      .switch_change_irq_n_oe(irq_oe), .overtemp_warn_n_o(ot_o), .overtemp_warn_n_oe(ot_oe),
      .direct_out0(direct_out0), .direct_out1(direct_out1), .direct_out_oe(direct_out_oe),
      .sense_enable(sense_enable), .wetting_enable(wetting_enable),
      .battery_reference(battery_reference), .hysteresis_enable(hysteresis_enable));
   scm_spi_master scm_spi_master_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(sdo_line));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic spi(input int n);
      scm_spi_master_i.xfer(cmd, n, rd);
      cyc(2);
   endtask
   // Toggles inputs; the alert must stay quiet for the whole debounce time.
   task automatic flip(input logic [7:0] m, input logic irq_exp);
      switch_inputs = switch_inputs ^ m;
      cyc(DEB);
      chk(irq_pin, 1'b1);
      cyc(30);
      chk(irq_pin, !irq_exp);
   endtask
   task automatic t_start();
      shutdown_n = 1'b1;
      cyc(60);
      spi(16);
      base = rd;
      chk(base & 16'hFE03, 16'h0000);
      chk(irq_pin, 1'b1);
      chk(sense_enable, 8'hFC);
      chk(direct_out_oe, 1'b1);
      flip(8'h01, 1'b0);
      chk(direct_out0, 1'b1);
      switch_inputs = switch_inputs ^ 8'h02;
      cyc(8);
      chk(direct_out1, 1'b1);
      switch_inputs = switch_inputs ^ 8'h02;
      cyc(50);
      chk(direct_out1, 1'b0);
      chk(irq_pin, 1'b1);
      spi(16);
      chk(rd, base);
   endtask
   task automatic t_change();
      flip(8'h04, 1'b1);
      spi(16);
      chk(rd, base ^ 16'h0004);
      chk(irq_pin, 1'b1);
      base = rd;
      switch_inputs = switch_inputs ^ 8'h08;
      cyc(10);
      switch_inputs = switch_inputs ^ 8'h08;
      cyc(50);
      chk(irq_pin, 1'b1);
      // A longer terminal count must delay the report accordingly.
      deb_cycles = 25'h3C;
      switch_inputs = switch_inputs ^ 8'h08;
      cyc(50);
      chk(irq_pin, 1'b1);
      cyc(30);
      chk(irq_pin, 1'b0);
      deb_cycles = 25'h14;
      switch_inputs = switch_inputs ^ 8'h08;
      cyc(50);
      spi(16);
      chk(rd, base);
   endtask
   task automatic t_cmd();
      cmd = 16'h1510;
      spi(16);
      cyc(50);
      spi(16);
      base = rd;
      chk(battery_reference, 8'h30);
      chk(hysteresis_enable, 1'b1);
      chk(sense_enable, 8'hFF);
      chk(direct_out_oe, 1'b0);
      flip(8'h10, 1'b0);
      spi(16);
      chk(rd, base ^ 16'h0010);
      base = rd;
      flip(8'h20, 1'b1);
      cmd = 16'h1710;
      spi(15);
      chk(battery_reference, 8'h30);
      spi(16);
      chk(battery_reference, 8'hF0);
      cyc(50);
      spi(16);
      base = rd;
   endtask
   task automatic t_therm();
      // Wetting on: closed switches get current until the thermal warning.
      cmd = 16'h1F10;
      spi(16);
      chk(wetting_enable, 8'h3A);
      thermal_warn = 1'b1;
      cyc(8);
      chk(ot_pin, 1'b0);
      chk(wetting_enable, 8'h00);
      spi(16);
      chk(rd[8], 1'b1);
      thermal_warn = 1'b0;
      cyc(8);
      spi(16);
      chk(rd, base);
   endtask
   task automatic t_shut();
      shutdown_n = 1'b0;
      cyc(8);
      chk(sense_enable, 8'h00);
      flip(8'h08, 1'b0);
      shutdown_n = 1'b1;
      cyc(8);
      chk(sense_enable, 8'hFF);
      cyc(50);
      spi(16);
      chk(rd, base ^ 16'h0008);
      base = rd;
   endtask
   task automatic t_scan();
      int on;
      on = 0;
      cmd = 16'h3710;
      spi(16);
      repeat (6600) begin
         cyc(1);
         if (sense_enable !== 8'h00) on++;
      end
      chk(on > 0 && on < 3300, 1'b1);
      switch_inputs = switch_inputs ^ 8'h40;
      for (int i = 0; i < 7400 && irq_pin; i++) cyc(1);
      chk(irq_pin, 1'b0);
      spi(16);
      chk(rd, base ^ 16'h0040);
   endtask
   initial begin
      rst_n = 1'b0;
      thermal_warn = 1'b0;
      shutdown_n = 1'b0;
      switch_inputs = 8'h00;
      cmd = 16'h0000;
      deb_cycles = 25'h14;
      cyc(20);
      chk(battery_reference, 8'h00);
      chk(irq_pin, 1'b1);
      rst_n = 1'b1;
      t_start();
      t_change();
      t_cmd();
      t_therm();
      t_shut();
      t_scan();
      complete_run();
   end
endmodule
